// ---- core/sba_pkg.sv ----
package sba_pkg;

    // ---------------------------------------------------------------
    // Sizes
    // ---------------------------------------------------------------
    localparam int SBA_DEPTH = 16;
    localparam int SBA_WIDTH = 16;
    localparam int SBA_PTR_W = 4;
    localparam int SBA_CNT_W = 5;
    localparam int SBA_RES_W = 12;
    localparam int SBA_ACC_W = 16;
    localparam int SBA_CLOCKS_PER_CONVERSION_W = 8;
    localparam int SBA_CHANNELS = 2;

    // ---------------------------------------------------------------
    // Counts, codes and reset values
    // ---------------------------------------------------------------
    localparam logic [4:0] SBA_FULL_COUNT = 5'h10;
    localparam logic [4:0] SBA_ACC_SAMPLES = 5'h10;
    localparam logic [7:0] SBA_GC_ADDR = 8'h00;
    localparam logic [7:0] SBA_GC_RELATCH = 8'h04;
    localparam logic [6:0] SBA_ADDR_UPPER_TOP = 7'h1F;
    localparam logic [6:0] SBA_ADDR_LOWER_BASE = 7'h18;
    localparam logic [2:0] SBA_RELATCH_CYCLES = 3'h4;
    localparam logic [15:0] SBA_ACC_RESET = 16'h0000;
    localparam logic SBA_OSC_LOW_POWER = 1'b1;
    localparam logic SBA_FILL_STOP_FULL = 1'b0;
    localparam logic SBA_FMT_LEFT = 1'b0;

    // ---------------------------------------------------------------
    // Field positions
    // ---------------------------------------------------------------
    localparam int SBA_TAG_VALID_BIT = 0;
    localparam int SBA_TAG_CHAN_BIT = 1;
    localparam int SBA_ENT_VALID_POS = 0;
    localparam int SBA_ENT_CHAN_POS = 3;
    localparam int SBA_ENT_RES_POS = 4;

    // ---------------------------------------------------------------
    // Types
    // ---------------------------------------------------------------
    typedef struct packed {
        logic oscillator_select;
        logic [7:0] conversion_clock_count;
        logic buffer_fill_policy;
        logic [1:0] sequence_channel_enable;
        logic entry_format;
        logic [1:0] tag_config;
        logic precision_mode;
    } sba_cfg_t;

    typedef struct packed {
        logic scl;
        logic sda;
    } sba_i2c_in_t;

    typedef struct packed {
        logic sda_o;
        logic sda_oe_n;
    } sba_i2c_out_t;

    typedef enum logic [7:0] {
        SBA_IDLE = 8'h01,
        SBA_ADDR = 8'h02,
        SBA_ADDR_ACK = 8'h04,
        SBA_RD_BYTE = 8'h08,
        SBA_RD_ACK = 8'h10,
        SBA_GC_BYTE = 8'h20,
        SBA_GC_ACK = 8'h40,
        SBA_SKIP = 8'h80
    } sba_i2c_state_t;

    // Strap level to target address
    function automatic logic [6:0] sba_strap_address(input logic [2:0] code);
        if (code[2]) begin
            return SBA_ADDR_LOWER_BASE + {5'h00, code[1:0]};
        end
        return SBA_ADDR_UPPER_TOP - {5'h00, code[1:0]};
    endfunction

endpackage

// ---- core/sba_fifo_mem.sv ----
`timescale 1ns/1ps
module sba_fifo_mem
    import sba_pkg::*;
#(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16,
    parameter int AW = 4
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Write port
    input wire logic i_we,
    input wire logic [AW-1:0] i_waddr,
    input wire logic [WIDTH-1:0] i_wdata,
    // Read port
    input wire logic [AW-1:0] i_raddr,
    output logic [WIDTH-1:0] o_rdata
);
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [WIDTH-1:0] rdata;
    } sba_mem_state_t;

    sba_mem_state_t s_q;
    sba_mem_state_t s_d;

    // Write and registered read
    always_comb begin
        s_d = s_q;
        if (i_we) begin
            s_d.mem[i_waddr] = i_wdata;
        end
        s_d.rdata = s_q.mem[i_raddr];
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign o_rdata = s_q.rdata;
endmodule // sba_fifo_mem

// ---- core/sba_strap_latch.sv ----
`timescale 1ns/1ps
module sba_strap_latch
    import sba_pkg::*;
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Strap sampling
    input wire logic i_load,
    input wire logic [2:0] i_strap_code,
    output logic [6:0] o_address
);
    typedef struct packed {
        logic [6:0] address;
    } sba_strap_state_t;

    sba_strap_state_t s_q;
    sba_strap_state_t s_d;

    // Capture decoded strap only on a load pulse
    always_comb begin
        s_d = s_q;
        if (i_load) begin
            s_d.address = sba_strap_address(i_strap_code);
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            s_q.address <= SBA_ADDR_UPPER_TOP;
        end else begin
            s_q <= s_d;
        end
    end

    assign o_address = s_q.address;
endmodule // sba_strap_latch

// ---- core/sba_core.sv ----
`timescale 1ns/1ps
// How it works
// - Low-power oscillator when select is 1
// - Rate is oscillator over clocks per conversion
// - Address latched at power-up and on relatch, kept until reset
// - Strap picks one of eight fixed addresses
// - Buffer is sixteen words of sixteen bits
// - Fill policy steers writes; fill count readable
// - Same channel spaced by channels times clocks
// - Entry format and optional channel, valid tags
// - Entries unwritten since launch read invalid
// - Reads past valid words return zero words
// - Filled in conversion order, at most sixteen
// - Unwritten entries during sequence hold zeros
// - Busy drops at completion or abort
// - Read frame returns entries oldest first
// - Read during busy returns zero words
// - Launch or reset clears the buffer
// - Accumulator per channel, only if sequenced
// - Sixteen 12-bit results summed into 16 bits
// - Accumulator readable as upper, lower byte
// - Progress count readable during sequence
// - Launch or reset clears accumulators
// - Enabled channel bit joins the scan
// - General call 04h re-derives address, holds busy
module sba_core
    import sba_pkg::*;
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Configuration and control
    input wire sba_cfg_t i_cfg,
    input wire logic i_sequence_launch,
    input wire logic i_sequence_abort,
    // Oscillators and converter
    input wire logic i_lp_osc_tick,
    input wire logic i_hs_osc_tick,
    input wire logic [11:0] i_adc_result,
    // Address strap
    input wire logic [2:0] i_strap_code,
    // I2C pins
    input wire sba_i2c_in_t i_i2c,
    output sba_i2c_out_t o_i2c,
    // Status
    output logic o_busy,
    output logic [4:0] o_fill_count,
    output logic [1:0][4:0] o_accum_progress,
    output logic [1:0][7:0] o_accum_upper_byte,
    output logic [1:0][7:0] o_accum_lower_byte,
    output logic [6:0] o_target_address
);
    typedef struct packed {
        logic seq_active;
        logic busy;
        logic strap_load;
        logic [2:0] relatch_cnt;
        logic [7:0] osc_cnt;
        logic ch;
        logic [3:0] wr_ptr;
        logic [4:0] fill;
        logic wrapped;
        logic [15:0] written;
        logic [1:0][15:0] acc;
        logic [1:0][4:0] acc_n;
        logic [4:0] rd_done;
        sba_i2c_state_t st;
        logic [3:0] bit_cnt;
        logic [7:0] shift;
        logic [15:0] tx;
        logic byte_lo;
        logic is_read;
        logic zero_frame;
        logic ack_seen;
        logic sda_oe_n;
        logic scl_q;
        logic sda_q;
    } sba_state_t;

    sba_state_t s;
    sba_state_t n;
    logic mem_we;
    logic [3:0] mem_waddr;
    logic [15:0] mem_wdata;
    logic [15:0] mem_rdata;
    logic [3:0] rd_idx;
    logic deliverable;
    logic strap_load_pulse;
    logic osc_pulse;
    logic [7:0] clocks_per_conversion_m1;
    logic conv_done;
    logic [1:0] eff_en;
    logic scl_rise;
    logic scl_fall;
    logic bus_start;
    logic bus_stop;
    logic [6:0] address;
    logic load_word;

    // ---------------------------------------------------------------
    // Helpers
    // ---------------------------------------------------------------
    // Next channel in the scan; stays put when alone
    function automatic logic next_channel(input logic [1:0] en, input logic ch);
        return en[~ch] ? ~ch : ch;
    endfunction

    // Pack one result into a buffer word
    function automatic logic [15:0] format_entry(input sba_cfg_t cfg, input logic [11:0] res, input logic ch);
        logic [15:0] w;
        w = 16'h0000;
        if (cfg.entry_format == SBA_FMT_LEFT) begin
            w[SBA_ENT_RES_POS +: SBA_RES_W] = res;
            w[SBA_ENT_CHAN_POS] = cfg.tag_config[SBA_TAG_CHAN_BIT] & ch;
            w[SBA_ENT_VALID_POS] = cfg.tag_config[SBA_TAG_VALID_BIT];
        end else begin
            w[SBA_RES_W-1:0] = res;
        end
        return w;
    endfunction

    // ---------------------------------------------------------------
    // Sub-blocks
    // ---------------------------------------------------------------
    sba_fifo_mem #(
        .WIDTH(SBA_WIDTH),
        .DEPTH(SBA_DEPTH),
        .AW(SBA_PTR_W)
    ) u_mem (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_we(mem_we),
        .i_waddr(mem_waddr),
        .i_wdata(mem_wdata),
        .i_raddr(rd_idx),
        .o_rdata(mem_rdata)
    );

    sba_strap_latch u_strap (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_load(strap_load_pulse),
        .i_strap_code(i_strap_code),
        .o_address(address)
    );

    // ---------------------------------------------------------------
    // Combinational decode
    // ---------------------------------------------------------------
    // oscillator choice
    assign osc_pulse = (i_cfg.oscillator_select == SBA_OSC_LOW_POWER) ? i_lp_osc_tick : i_hs_osc_tick;
    assign clocks_per_conversion_m1 = (i_cfg.conversion_clock_count == 8'h00) ? 8'h00 : i_cfg.conversion_clock_count - 8'h01;
    assign conv_done = s.seq_active & osc_pulse & (s.osc_cnt >= clocks_per_conversion_m1);
    // empty enable treated as channel 0
    assign eff_en = (i_cfg.sequence_channel_enable == 2'h0) ? 2'h1 : i_cfg.sequence_channel_enable;
    assign scl_rise = i_i2c.scl & ~s.scl_q;
    assign scl_fall = ~i_i2c.scl & s.scl_q;
    assign bus_start = i_i2c.scl & s.scl_q & s.sda_q & ~i_i2c.sda;
    assign bus_stop = i_i2c.scl & s.scl_q & ~s.sda_q & i_i2c.sda;
    assign rd_idx = (s.wrapped ? s.wr_ptr : 4'h0) + s.rd_done[3:0];
    // only written, undelivered words outside busy
    assign deliverable = ~s.zero_frame & (s.rd_done < s.fill) & s.written[rd_idx];
    // strap sampled after reset and after relatch
    assign strap_load_pulse = s.strap_load | (s.relatch_cnt == 3'h1);

    // ---------------------------------------------------------------
    // Next state
    // ---------------------------------------------------------------
    always_comb begin
        n = s;
        mem_we = 1'b0;
        mem_waddr = s.wr_ptr;
        mem_wdata = format_entry(i_cfg, i_adc_result, s.ch);
        n.strap_load = 1'b0;
        load_word = 1'b0;
        n.scl_q = i_i2c.scl;
        n.sda_q = i_i2c.sda;
        if (s.relatch_cnt != 3'h0) begin
            n.relatch_cnt = s.relatch_cnt - 3'h1;
        end
        // Conversion sequence
        if (i_sequence_launch) begin
            n.seq_active = 1'b1;
            n.osc_cnt = 8'h00;
            n.ch = ~eff_en[0];
            n.wr_ptr = 4'h0;
            n.fill = 5'h00;
            n.wrapped = 1'b0;
            n.written = 16'h0000;
            n.acc = {SBA_ACC_RESET, SBA_ACC_RESET};
            n.acc_n = '0;
            n.rd_done = 5'h00;
        end else if (i_sequence_abort) begin
            n.seq_active = 1'b0;
        end else if (s.seq_active && osc_pulse) begin
            n.osc_cnt = conv_done ? 8'h00 : s.osc_cnt + 8'h01;
            if (conv_done) begin
                n.ch = next_channel(eff_en, s.ch);
                if (i_cfg.precision_mode) begin
                    if (eff_en[s.ch] && s.acc_n[s.ch] < SBA_ACC_SAMPLES) begin
                        n.acc[s.ch] = s.acc[s.ch] + {4'h0, i_adc_result};
                        n.acc_n[s.ch] = s.acc_n[s.ch] + 5'h01;
                    end
                    if ((~eff_en[0] || n.acc_n[0] == SBA_ACC_SAMPLES)
                        && (~eff_en[1] || n.acc_n[1] == SBA_ACC_SAMPLES)) begin
                        n.seq_active = 1'b0;
                    end
                end else begin
                    // write formatted entry by fill policy
                    mem_we = 1'b1;
                    n.written[s.wr_ptr] = 1'b1;
                    n.wr_ptr = s.wr_ptr + 4'h1;
                    if (s.fill < SBA_FULL_COUNT) begin
                        n.fill = s.fill + 5'h01;
                    end else begin
                        n.wrapped = 1'b1;
                    end
                    if (i_cfg.buffer_fill_policy == SBA_FILL_STOP_FULL && n.fill == SBA_FULL_COUNT) begin
                        n.seq_active = 1'b0;
                    end
                end
            end
        end
        // I2C target
        if (bus_start) begin
            n.st = SBA_ADDR;
            n.bit_cnt = 4'h0;
            n.sda_oe_n = 1'b1;
        end else if (bus_stop) begin
            n.st = SBA_IDLE;
            n.sda_oe_n = 1'b1;
        end else begin
            unique case (s.st)
                SBA_IDLE, SBA_SKIP: begin
                    n.sda_oe_n = 1'b1;
                end
                SBA_ADDR, SBA_GC_BYTE: begin
                    if (scl_rise) begin
                        n.shift = {s.shift[6:0], i_i2c.sda};
                        n.bit_cnt = s.bit_cnt + 4'h1;
                    end else if (scl_fall && s.bit_cnt == 4'h8) begin
                        n.bit_cnt = 4'h0;
                        n.st = SBA_SKIP;
                        if (s.st == SBA_GC_BYTE) begin
                            if (s.shift == SBA_GC_RELATCH) begin
                                n.relatch_cnt = SBA_RELATCH_CYCLES;
                                n.sda_oe_n = 1'b0;
                                n.st = SBA_GC_ACK;
                            end
                        end else if (s.shift == SBA_GC_ADDR) begin
                            n.is_read = 1'b0;
                            n.sda_oe_n = 1'b0;
                            n.st = SBA_ADDR_ACK;
                        end else if (s.shift == {address, 1'b1} && s.relatch_cnt == 3'h0) begin
                            n.is_read = 1'b1;
                            n.zero_frame = s.busy;
                            n.sda_oe_n = 1'b0;
                            n.st = SBA_ADDR_ACK;
                        end
                    end
                end
                SBA_ADDR_ACK, SBA_GC_ACK: begin
                    if (scl_fall) begin
                        n.sda_oe_n = 1'b1;
                        n.st = (s.st == SBA_ADDR_ACK) ? SBA_GC_BYTE : SBA_SKIP;
                        load_word = (s.st == SBA_ADDR_ACK) & s.is_read;
                    end
                end
                SBA_RD_BYTE: begin
                    if (scl_fall) begin
                        // Release for the acknowledge after eight bits
                        n.shift = {s.shift[6:0], 1'b1};
                        n.sda_oe_n = (s.bit_cnt[2:0] == 3'h7) | s.shift[6];
                        n.bit_cnt = s.bit_cnt + 4'h1;
                        n.st = (s.bit_cnt[2:0] == 3'h7) ? SBA_RD_ACK : SBA_RD_BYTE;
                    end
                end
                SBA_RD_ACK: begin
                    if (scl_rise) begin
                        n.ack_seen = ~i_i2c.sda;
                    end else if (scl_fall && !s.ack_seen) begin
                        n.st = SBA_SKIP;
                    end else if (scl_fall && !s.byte_lo) begin
                        n.shift = s.tx[7:0];
                        n.sda_oe_n = s.tx[7];
                        n.byte_lo = 1'b1;
                        n.st = SBA_RD_BYTE;
                    end else if (scl_fall) begin
                        load_word = 1'b1;
                    end
                end
                default: begin
                    n.st = SBA_IDLE;
                end
            endcase
        end
        if (load_word) begin
            n.tx = deliverable ? mem_rdata : 16'h0000;
            n.shift = n.tx[15:8];
            n.sda_oe_n = n.tx[15];
            n.byte_lo = 1'b0;
            n.st = SBA_RD_BYTE;
            if (deliverable) begin
                n.rd_done = s.rd_done + 5'h01;
            end
        end
        n.busy = n.seq_active | (n.relatch_cnt != 3'h0) | n.strap_load;
    end

    // State register; pin samples start at idle high
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            s <= '{st: SBA_IDLE, sda_oe_n: 1'b1, scl_q: 1'b1, sda_q: 1'b1, strap_load: 1'b1, busy: 1'b1,
                default: '0};
        end else begin
            s <= n;
        end
    end

    // Outputs straight from state flops
    assign o_busy = s.busy;
    assign o_fill_count = s.fill;
    assign o_accum_progress = s.acc_n;
    assign o_target_address = address;
    assign o_i2c = {s.sda_oe_n, s.sda_oe_n}; // Drives only zero
    for (genvar c = 0; c < SBA_CHANNELS; c++) begin : g_acc_bytes
        assign o_accum_upper_byte[c] = s.acc[c][15:8];
        assign o_accum_lower_byte[c] = s.acc[c][7:0];
    end

    sequence relatch_armed;
        s.relatch_cnt == SBA_RELATCH_CYCLES;
    endsequence
    sequence strap_reloaded;
        ##3 strap_load_pulse;
    endsequence
    a_fill_bounded: assert property (@(posedge i_clk) disable iff (i_rst)
        s.fill <= SBA_FULL_COUNT) else $error("fill count above depth");
    a_launch_clears: assert property (@(posedge i_clk) disable iff (i_rst)
        i_sequence_launch |=> s.fill == 5'h00 && s.acc_n == '0) else $error("launch left buffer or accumulators");
    a_abort_stops: assert property (@(posedge i_clk) disable iff (i_rst)
        i_sequence_abort && !i_sequence_launch |=> !s.seq_active) else $error("abort did not stop sequence");
    a_acc_capped: assert property (@(posedge i_clk) disable iff (i_rst)
        s.acc_n[0] <= SBA_ACC_SAMPLES && s.acc_n[1] <= SBA_ACC_SAMPLES) else $error("too many accumulations");
    a_relatch_reload: assert property (@(posedge i_clk) disable iff (i_rst)
        relatch_armed |-> strap_reloaded) else $error("strap not reloaded after relatch");
    a_busy_read_zero: assert property (@(posedge i_clk) disable iff (i_rst)
        s.zero_frame && s.st == SBA_RD_BYTE |-> s.tx == 16'h0000) else $error("busy frame sent data");
endmodule // sba_core

// ---- verif/sba_host_model.sv ----
`timescale 1ns/1ps
module sba_host_model #(
    parameter int QTR = 5
) (
    // Clock and bus lines
    input wire logic i_clk,
    input wire logic i_sda,
    output logic o_scl,
    output logic o_sda_low
);
    logic [15:0] words [0:19];
    logic addr_ack;

    // Bus idle, both lines released
    initial begin
        o_scl = 1'h1;
        o_sda_low = 1'h0;
    end

    // Quarter of a bit time
    task automatic qw();
        repeat (QTR) @(negedge i_clk);
    endtask

    // One bit: change while low, sample while high
    task automatic slot(input logic b, output logic s);
        o_sda_low = !b;
        qw();
        o_scl = 1'h1;
        qw();
        s = i_sda;
        qw();
        o_scl = 1'h0;
        qw();
    endtask

    // Addressed read of n words
    task automatic read_frame(input logic [6:0] addr, input int n);
        logic s;
        logic [7:0] b;
        o_sda_low = 1'h1;
        qw();
        o_scl = 1'h0;
        qw();
        for (int i = 6; i >= 0; i--) begin
            slot(addr[i], s);
        end
        slot(1'h1, s);
        slot(1'h1, s);
        addr_ack = !s;
        for (int w = 0; w < n; w++) begin
            for (int k = 0; k < 2; k++) begin
                for (int i = 7; i >= 0; i--) begin
                    slot(1'h1, s);
                    b[i] = s;
                end
                if (k == 0) begin
                    words[w][15:8] = b;
                end else begin
                    words[w][7:0] = b;
                end
                slot(w == n - 1 && k == 1, s);
            end
        end
        o_sda_low = 1'h1;
        qw();
        o_scl = 1'h1;
        qw();
        o_sda_low = 1'h0;
        qw();
    endtask
endmodule // sba_host_model

// ---- verif/sample_buffer_accumulator_tb.sv ----
`timescale 1ns/1ps
module sample_buffer_accumulator_tb;
    import sba_pkg::*;
    localparam logic [6:0] EXP_ADDR [8] = '{7'h1F, 7'h1E, 7'h1D, 7'h1C, 7'h18, 7'h19, 7'h1A, 7'h1B};
    localparam logic [11:0] RES = 12'h5A3;
    logic i_clk;
    logic i_rst;
    logic launch;
    logic abort;
    logic lp_tick;
    logic hs_tick;
    logic scl;
    logic sda_low;
    logic sda;
    logic [2:0] strap;
    logic [11:0] adc;
    sba_cfg_t cfg;
    sba_i2c_in_t i2c_i;
    sba_i2c_out_t i2c_o;
    logic o_busy;
    logic [4:0] fill;
    logic [1:0][4:0] prog;
    logic [1:0][7:0] up;
    logic [1:0][7:0] lo;
    logic [6:0] taddr;
    int err_count;
    int n_tests;
    int ph;

    // Clock
    initial begin
        i_clk = 1'h0;
        forever #5 i_clk = ~i_clk;
    end

    // Fast tick every 2 cycles, slow tick every 8
    always @(negedge i_clk) begin
        ph <= ph + 1;
        hs_tick <= ph[0];
        lp_tick <= (ph[2:0] == 3'h7);
    end

    // Open-drain data line with pull-up
    assign sda = !(sda_low || (!i2c_o.sda_oe_n && !i2c_o.sda_o));
    assign i2c_i.scl = scl;
    assign i2c_i.sda = sda;

    sba_core u_sba_core (.i_clk(i_clk), .i_rst(i_rst), .i_cfg(cfg), .i_sequence_launch(launch),
        .i_sequence_abort(abort), .i_lp_osc_tick(lp_tick), .i_hs_osc_tick(hs_tick), .i_adc_result(adc),
        .i_strap_code(strap), .i_i2c(i2c_i), .o_i2c(i2c_o), .o_busy(o_busy), .o_fill_count(fill),
        .o_accum_progress(prog), .o_accum_upper_byte(up), .o_accum_lower_byte(lo), .o_target_address(taddr));

    sba_host_model u_sba_host_model (.i_clk(i_clk), .i_sda(sda), .o_scl(scl), .o_sda_low(sda_low));

    task automatic tally_and_finish();
        $display("Comparisons %0d, mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic do_reset();
        i_rst = 1'h1;
        repeat (8) @(negedge i_clk);
        i_rst = 1'h0;
        @(negedge i_clk);
    endtask

    task automatic setcfg(input logic osc, input logic [1:0] chen, input logic prec);
        cfg.oscillator_select = osc;
        cfg.conversion_clock_count = 8'h04;
        cfg.buffer_fill_policy = SBA_FILL_STOP_FULL;
        cfg.sequence_channel_enable = chen;
        cfg.entry_format = SBA_FMT_LEFT;
        cfg.tag_config = 2'h3;
        cfg.precision_mode = prec;
    endtask

    // One-cycle launch or abort
    task automatic pulse(input logic ab);
        abort = ab;
        launch = !ab;
        @(negedge i_clk);
        abort = 1'h0;
        launch = 1'h0;
        @(negedge i_clk);
    endtask

    // Bounded wait: 0 fill count, 1 busy, 2 channel 0 progress
    task automatic wait_sig(input int which, input logic [4:0] v);
        int c;
        c = 0;
        while (c < 3000 && !((which == 0 && fill === v) || (which == 1 && o_busy === v[0])
               || (which == 2 && prog[0] === v))) begin
            @(negedge i_clk);
            c++;
        end
        if (c == 3000) begin
            err_count++;
            $display("MISMATCH wait %0d expected %h seen timeout", which, v);
            tally_and_finish();
        end
    endtask

    // Cycles between two fill count steps
    task automatic gap(input logic [15:0] exp);
        logic [4:0] f;
        int c;
        f = fill;
        c = 0;
        while (fill === f && c < 5000) begin
            @(negedge i_clk);
            c++;
        end
        check("conv_gap", exp, c[15:0]);
    endtask

    // Main sequence
    initial begin
        err_count = 0;
        n_tests = 0;
        ph = 0;
        hs_tick = 1'h0;
        lp_tick = 1'h0;
        launch = 1'h0;
        abort = 1'h0;
        i_rst = 1'h1;
        strap = 3'h0;
        adc = RES;
        setcfg(1'h0, 2'h1, 1'h0);
        for (int k = 0; k < 8; k++) begin
            strap = k[2:0];
            do_reset();
            check("target_addr", {9'h000, EXP_ADDR[k]}, {9'h000, taddr});
        end
        strap = 3'h0;
        repeat (20) @(negedge i_clk);
        check("addr_hold", {9'h000, EXP_ADDR[7]}, {9'h000, taddr});
        check("fill_rst", 16'h0000, {11'h000, fill});
        check("acc_rst", 16'h0000, {up[0], lo[0]});
        // Rate on both oscillators, one channel
        pulse(1'h0);
        wait_sig(0, 5'h01);
        gap(16'h0008);
        pulse(1'h1);
        wait_sig(1, 5'h00);
        setcfg(1'h1, 2'h1, 1'h0);
        pulse(1'h0);
        check("fill_clr", 16'h0000, {11'h000, fill});
        wait_sig(0, 5'h01);
        gap(16'h0020);
        pulse(1'h1);
        // Fill with two channels, then read out
        setcfg(1'h0, 2'h3, 1'h0);
        pulse(1'h0);
        wait_sig(0, 5'h10);
        repeat (40) @(negedge i_clk);
        check("fill_max", 16'h0010, {11'h000, fill});
        pulse(1'h1);
        wait_sig(1, 5'h00);
        u_sba_host_model.read_frame(EXP_ADDR[7], 17);
        check("addr_ack", 16'h0001, {15'h0000, u_sba_host_model.addr_ack});
        for (int i = 0; i < 16; i++) begin
            check("entry", {RES, i[0], 3'h1}, u_sba_host_model.words[i]);
        end
        check("entry_17", 16'h0000, u_sba_host_model.words[16]);
        u_sba_host_model.read_frame(EXP_ADDR[7], 1);
        check("reread", 16'h0000, u_sba_host_model.words[0]);
        // Read while a slow sequence runs
        setcfg(1'h1, 2'h3, 1'h0);
        pulse(1'h0);
        repeat (4) @(negedge i_clk);
        check("busy", 16'h0001, {15'h0000, o_busy});
        u_sba_host_model.read_frame(EXP_ADDR[7], 1);
        check("busy_read", 16'h0000, u_sba_host_model.words[0]);
        pulse(1'h1);
        wait_sig(1, 5'h00);
        // Accumulate channel 0 only
        adc = 12'hFFF;
        setcfg(1'h0, 2'h1, 1'h1);
        pulse(1'h0);
        wait_sig(2, 5'h10);
        repeat (2) @(negedge i_clk);
        check("acc_ch0", 16'hFFF0, {up[0], lo[0]});
        check("acc_ch1", 16'h0000, {up[1], lo[1]});
        check("prog_ch1", 16'h0000, {11'h000, prog[1]});
        pulse(1'h1);
        wait_sig(1, 5'h00);
        pulse(1'h0);
        check("acc_clr", 16'h0000, {up[0], lo[0]});
        pulse(1'h1);
        tally_and_finish();
    end
endmodule // sample_buffer_accumulator_tb
